// *** hw/plcr_consts.vh ***
// Constants for the power loop configuration register slice.
`ifndef PLCR_CONSTS_VH
`define PLCR_CONSTS_VH
`define PLCR_ADDR_OFS_HI   8'h34
`define PLCR_ADDR_OFS_LO   8'h35
`define PLCR_ADDR_C2_TIM   8'h36
`define PLCR_ADDR_C2_STEP  8'h37
`define PLCR_ADDR_C2_CFG   8'h38
`define PLCR_ADDR_SPARE    8'h39
`define PLCR_ADDR_C1_TIM   8'h3A
`define PLCR_ADDR_C1_STEP  8'h3B
`define PLCR_RST_VAL       8'h00
`define PLCR_MASK_OFS_HI   8'h1F
`define PLCR_OFS_HI_MSB    4
`define PLCR_MASK_STEP     8'hF3
`define PLCR_MASK_CFG      8'hFE
`define PLCR_DEC_MSB       7
`define PLCR_DEC_LSB       5
`define PLCR_OFS_BIT       4
`define PLCR_LINE_BIT      3
`define PLCR_FB_MSB        2
`define PLCR_FB_LSB        1
`define PLCR_FB_OFF        2'h3
`define PLCR_INIT_MSB      7
`define PLCR_INIT_LSB      6
`define PLCR_MID_MSB       5
`define PLCR_MID_LSB       4
`define PLCR_MIN_MSB       3
`define PLCR_MIN_LSB       2
`define PLCR_DIV_MSB       1
`define PLCR_DIV_LSB       0
`define PLCR_CNT_L1        8'h3F
`define PLCR_CNT_L2        8'h7F
`define PLCR_CNT_L3        8'hFF
`define PLCR_CNT_S1        8'h1F
`define PLCR_CNT_S2        8'h3F
`define PLCR_CNT_S3        8'h7F
`define PLCR_STEP_I0       8'h01
`define PLCR_STEP_I1       8'h08
`define PLCR_STEP_I2       8'h10
`define PLCR_STEP_I3       8'h20
`define PLCR_CKDIV_0       5'h01
`define PLCR_CKDIV_1       5'h04
`define PLCR_CKDIV_2       5'h08
`define PLCR_CKDIV_3       5'h10
`endif

// *** hw/plcr_regs.v ***
// Power loop configuration register slice with field decoding.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - The 3-bit decimation code selects a filter factor of two to the power of the code, 1 up to 128.
// - With offset refresh set the offset is updated in blanking after channel-on, otherwise zero current is driven in blanking.
// - The feedback select code picks monitor input 0, 1 or 2, and code 11 turns the power loop off.
// - The initial dwell code maps to 0, 63, 127 or 255 loop clock counts.
// - With line gating set the output is enabled only while the line strobe is high, otherwise the strobe is ignored.
// - The mid step is one half or one quarter of the initial step for codes 00 and 01, and 10 and 11 are reserved.
`include "plcr_consts.vh"
module plcr_regs (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_clk_en,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  input  wire [7:0]  i_addr,
  input  wire [7:0]  i_wr_data,
  input  wire        i_channel_on_signal,
  input  wire        i_blanking,
  input  wire        i_line_strobe,
  output reg  [7:0]  o_rd_data,
  output wire [12:0] o_offset_target,
  output wire [7:0]  o_decimation_factor,
  output wire [1:0]  o_feedback_input_select,
  output wire        o_loop_enable,
  output reg         o_offset_update,
  output reg         o_offset_zero,
  output reg         o_channel_output_enable,
  output wire [15:0] o_initial_dwell_count,
  output wire [15:0] o_mid_dwell_count,
  output wire [15:0] o_min_dwell_count,
  output wire [15:0] o_div_enable_count,
  output wire [9:0]  o_clock_divider,
  output wire [15:0] o_initial_step,
  output wire [15:0] o_mid_step_quarters,
  output wire [1:0]  o_mid_step_select_reserved
);

  reg  [7:0] ofs_hi_reg;
  reg  [7:0] ofs_lo_reg;
  reg  [7:0] cfg_reg;
  reg  [7:0] tim_reg [0:1];
  reg  [7:0] step_reg [0:1];
  reg  [7:0] rd_next;
  reg  [2:0] sync1_reg;
  reg  [2:0] sync2_reg;
  reg        on_seen_reg;
  wire       on_s;
  wire       blank_s;
  wire       strobe_s;

  function [7:0] long_cnt;
    input [1:0] code;
    begin
      case (code)
        2'h0:    long_cnt = 8'h00;
        2'h1:    long_cnt = `PLCR_CNT_L1;
        2'h2:    long_cnt = `PLCR_CNT_L2;
        default: long_cnt = `PLCR_CNT_L3;
      endcase
    end
  endfunction

  function [7:0] short_cnt;
    input [1:0] code;
    begin
      case (code)
        2'h0:    short_cnt = 8'h00;
        2'h1:    short_cnt = `PLCR_CNT_S1;
        2'h2:    short_cnt = `PLCR_CNT_S2;
        default: short_cnt = `PLCR_CNT_S3;
      endcase
    end
  endfunction

  function [7:0] init_step;
    input [1:0] code;
    begin
      case (code)
        2'h0:    init_step = `PLCR_STEP_I0;
        2'h1:    init_step = `PLCR_STEP_I1;
        2'h2:    init_step = `PLCR_STEP_I2;
        default: init_step = `PLCR_STEP_I3;
      endcase
    end
  endfunction

  function [4:0] ck_div;
    input [1:0] code;
    begin
      case (code)
        2'h0:    ck_div = `PLCR_CKDIV_0;
        2'h1:    ck_div = `PLCR_CKDIV_1;
        2'h2:    ck_div = `PLCR_CKDIV_2;
        default: ck_div = `PLCR_CKDIV_3;
      endcase
    end
  endfunction

  // Writes store only the implemented bits; reserved bits stay zero.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ofs_hi_reg  <= `PLCR_RST_VAL;
      ofs_lo_reg  <= `PLCR_RST_VAL;
      cfg_reg     <= `PLCR_RST_VAL;
      tim_reg[0]  <= `PLCR_RST_VAL;
      tim_reg[1]  <= `PLCR_RST_VAL;
      step_reg[0] <= `PLCR_RST_VAL;
      step_reg[1] <= `PLCR_RST_VAL;
    end else if (i_clk_en && i_wr_en) begin
      case (i_addr)
        `PLCR_ADDR_OFS_HI:  ofs_hi_reg  <= i_wr_data & `PLCR_MASK_OFS_HI;
        `PLCR_ADDR_OFS_LO:  ofs_lo_reg  <= i_wr_data;
        `PLCR_ADDR_C2_TIM:  tim_reg[1]  <= i_wr_data;
        `PLCR_ADDR_C2_STEP: step_reg[1] <= i_wr_data & `PLCR_MASK_STEP;
        `PLCR_ADDR_C2_CFG:  cfg_reg     <= i_wr_data & `PLCR_MASK_CFG;
        `PLCR_ADDR_C1_TIM:  tim_reg[0]  <= i_wr_data;
        `PLCR_ADDR_C1_STEP: step_reg[0] <= i_wr_data & `PLCR_MASK_STEP;
        default:            ofs_lo_reg  <= ofs_lo_reg;
      endcase
    end
  end

  // Unmapped and spare addresses read back as zero.
  always @* begin
    case (i_addr)
      `PLCR_ADDR_OFS_HI:  rd_next = ofs_hi_reg;
      `PLCR_ADDR_OFS_LO:  rd_next = ofs_lo_reg;
      `PLCR_ADDR_C2_TIM:  rd_next = tim_reg[1];
      `PLCR_ADDR_C2_STEP: rd_next = step_reg[1];
      `PLCR_ADDR_C2_CFG:  rd_next = cfg_reg;
      `PLCR_ADDR_C1_TIM:  rd_next = tim_reg[0];
      `PLCR_ADDR_C1_STEP: rd_next = step_reg[0];
      default:            rd_next = `PLCR_RST_VAL;
    endcase
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= `PLCR_RST_VAL;
    end else if (i_clk_en && i_rd_en) begin
      o_rd_data <= rd_next;
    end
  end

  // Pin inputs pass two flip-flops before any logic reads them.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else if (i_clk_en) begin
      sync1_reg <= {i_line_strobe, i_blanking, i_channel_on_signal};
      sync2_reg <= sync1_reg;
    end
  end

  assign on_s     = sync2_reg[0];
  assign blank_s  = sync2_reg[1];
  assign strobe_s = sync2_reg[2];

  // Field decoders are combinational from the stored bytes.
  assign o_offset_target = {ofs_hi_reg[`PLCR_OFS_HI_MSB:0], ofs_lo_reg};
  assign o_decimation_factor =
    8'h01 << cfg_reg[`PLCR_DEC_MSB:`PLCR_DEC_LSB];
  assign o_feedback_input_select = cfg_reg[`PLCR_FB_MSB:`PLCR_FB_LSB];
  assign o_loop_enable =
    (o_feedback_input_select != `PLCR_FB_OFF);

  // The channel-on flag is armed by channel-on and spent when a blanking period with an offset update ends.
  // Channel-on wins when it meets the clear in the same cycle.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      on_seen_reg             <= 1'b0;
      o_offset_update         <= 1'b0;
      o_offset_zero           <= 1'b0;
      o_channel_output_enable <= 1'b0;
    end else if (i_clk_en) begin
      if (on_s) begin
        on_seen_reg <= 1'b1;
      end else if (!blank_s && o_offset_update) begin
        on_seen_reg <= 1'b0;
      end
      o_offset_update <= cfg_reg[`PLCR_OFS_BIT] && blank_s
                         && (on_seen_reg || on_s);
      o_offset_zero   <= !cfg_reg[`PLCR_OFS_BIT] && blank_s;
      o_channel_output_enable <= on_s
        && (!cfg_reg[`PLCR_LINE_BIT] || strobe_s);
    end
  end

  // Index 0 is channel 1 and index 1 is channel 2.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      wire [7:0] ist;
      wire [1:0] msel;
      assign ist  = init_step(step_reg[ch][`PLCR_INIT_MSB:`PLCR_INIT_LSB]);
      assign msel = step_reg[ch][`PLCR_MID_MSB:`PLCR_MID_LSB];
      assign o_initial_dwell_count[ch*8 +: 8] =
        long_cnt(tim_reg[ch][`PLCR_INIT_MSB:`PLCR_INIT_LSB]);
      assign o_mid_dwell_count[ch*8 +: 8] =
        short_cnt(tim_reg[ch][`PLCR_MID_MSB:`PLCR_MID_LSB]);
      assign o_min_dwell_count[ch*8 +: 8] =
        short_cnt(tim_reg[ch][`PLCR_MIN_MSB:`PLCR_MIN_LSB]);
      assign o_div_enable_count[ch*8 +: 8] =
        long_cnt(tim_reg[ch][`PLCR_DIV_MSB:`PLCR_DIV_LSB]);
      assign o_clock_divider[ch*5 +: 5] =
        ck_div(step_reg[ch][`PLCR_DIV_MSB:`PLCR_DIV_LSB]);
      assign o_initial_step[ch*8 +: 8] = ist;
      // Quarter-LSB units keep half and quarter steps exact.
      // Reserved mid step codes give a zero step and raise the flag.
      assign o_mid_step_quarters[ch*8 +: 8] =
        (msel == 2'h0) ? {ist[6:0], 1'b0} :
        (msel == 2'h1) ? ist : 8'h00;
      assign o_mid_step_select_reserved[ch] = msel[1];
    end
  endgenerate

endmodule
`default_nettype wire

// *** tb/plcr_regs_props.sv ***
// Checker for the power loop configuration register slice.
`timescale 1ns/1ns
`default_nettype none
module plcr_regs_props (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_clk_en,
  input wire logic        i_wr_en,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wr_data,
  input wire logic        i_channel_on_signal,
  input wire logic        i_blanking,
  input wire logic [7:0]  o_decimation_factor,
  input wire logic [1:0]  o_feedback_input_select,
  input wire logic        o_loop_enable,
  input wire logic        o_offset_update,
  input wire logic        o_offset_zero,
  input wire logic        o_channel_output_enable,
  input wire logic [15:0] o_initial_dwell_count,
  input wire logic [1:0]  o_mid_step_select_reserved
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire w38 = i_clk_en && i_wr_en && i_addr == 8'h38;
  wire w3a = i_clk_en && i_wr_en && i_addr == 8'h3A;
  wire w3b = i_clk_en && i_wr_en && i_addr == 8'h3B;
  a_dec_factor: assert property (
    w38 |=> o_decimation_factor == 8'h01 << $past(i_wr_data[7:5]))
    else $error("decimation factor wrong");
  a_fb_select: assert property (
    w38 |=> o_feedback_input_select == $past(i_wr_data[2:1])
      && o_loop_enable == ($past(i_wr_data[2:1]) != 2'h3))
    else $error("feedback select wrong");
  a_init_dwell: assert property (
    w3a |=> o_initial_dwell_count[7:0] == ($past(i_wr_data[7:6]) == 2'h0 ?
      8'h00 : 8'hFF >> (2'h3 - $past(i_wr_data[7:6]))))
    else $error("dwell count wrong");
  a_mid_reserved: assert property (
    w3b |=> o_mid_step_select_reserved[0] == $past(i_wr_data[5]))
    else $error("mid step flag wrong");
  a_ofs_excl: assert property (
    !(o_offset_update && o_offset_zero))
    else $error("update and zero together");
  a_ofs_blank: assert property (
    o_offset_update || o_offset_zero |-> $past(i_blanking, 3))
    else $error("offset action outside blanking");
  a_gate_on: assert property (
    o_channel_output_enable |-> $past(i_channel_on_signal, 3))
    else $error("output enabled without channel on");
  a_reset_zero: assert property (
    $fell(i_sys_rst) |-> o_decimation_factor == 8'h01
      && o_initial_dwell_count == 16'h0000 && !o_offset_update)
    else $error("state after reset not zero");
  c_update: cover property (o_offset_update);
  c_zero: cover property (o_offset_zero);
  c_output: cover property (o_channel_output_enable);
endmodule
bind plcr_regs plcr_regs_props i_plcr_regs_props (
  .i_clk                      (i_clk),
  .i_sys_rst                  (i_sys_rst),
  .i_clk_en                   (i_clk_en),
  .i_wr_en                    (i_wr_en),
  .i_addr                     (i_addr),
  .i_wr_data                  (i_wr_data),
  .i_channel_on_signal        (i_channel_on_signal),
  .i_blanking                 (i_blanking),
  .o_decimation_factor        (o_decimation_factor),
  .o_feedback_input_select    (o_feedback_input_select),
  .o_loop_enable              (o_loop_enable),
  .o_offset_update            (o_offset_update),
  .o_offset_zero              (o_offset_zero),
  .o_channel_output_enable    (o_channel_output_enable),
  .o_initial_dwell_count      (o_initial_dwell_count),
  .o_mid_step_select_reserved (o_mid_step_select_reserved)
);
`default_nettype wire

// *** tb/plcr_regs_bench.sv ***
// Self-checking bench for the power loop configuration registers.
`timescale 1ns/1ns
`default_nettype none
module plcr_regs_bench;
  logic        clk = 0, rst = 1, en = 1, we = 0, re = 0;
  logic        on = 0, bl = 0, ls = 0, le, upd, zer, oe;
  logic [7:0]  adr = 0, wd = 0, rdat, dec;
  logic [1:0]  fb, rsv;
  logic [12:0] ot;
  logic [15:0] dw, ist, mq, mdw, ndw, vdw;
  logic [9:0]  cdv;
  logic [7:0]  dwt [4] = '{8'h00, 8'h3F, 8'h7F, 8'hFF};
  logic [7:0]  sdt [4] = '{8'h00, 8'h1F, 8'h3F, 8'h7F};
  logic [7:0]  stt [4] = '{8'h01, 8'h08, 8'h10, 8'h20};
  logic [4:0]  cdt [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
  int          failures = 0, n_compared = 0, cyc = 0;
  always #50 clk = ~clk;
  plcr_regs i_plcr_regs (.i_clk(clk), .i_sys_rst(rst), .i_clk_en(en),
    .i_wr_en(we), .i_rd_en(re), .i_addr(adr), .i_wr_data(wd),
    .i_channel_on_signal(on), .i_blanking(bl), .i_line_strobe(ls),
    .o_rd_data(rdat), .o_offset_target(ot), .o_decimation_factor(dec),
    .o_feedback_input_select(fb), .o_loop_enable(le),
    .o_offset_update(upd), .o_offset_zero(zer),
    .o_channel_output_enable(oe), .o_initial_dwell_count(dw),
    .o_mid_dwell_count(mdw), .o_min_dwell_count(ndw),
    .o_div_enable_count(vdw), .o_clock_divider(cdv),
    .o_initial_step(ist), .o_mid_step_quarters(mq),
    .o_mid_step_select_reserved(rsv));
  task automatic chk(input string n, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // Each bus task lets one idle edge pass so a strobe never toggles twice.
  task automatic wr(input logic [7:0] a, d);
    adr = a;
    wd = d;
    we = 1;
    @(negedge clk) we = 0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    adr = a;
    re = 1;
    @(negedge clk) re = 0;
    chk("read data", {8'h00, e}, {8'h00, rdat});
    @(negedge clk);
  endtask
  // Sets blanking and strobe, then waits out the pin synchronisers.
  task automatic pins(input logic b, s);
    bl = b;
    ls = s;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_regs;
    for (int a = 8'h34; a < 8'h3C; a++) rd(a[7:0], 8'h00);
    chk("dwell", 16'h0000, dw);
    chk("decimation", 16'h0001, dec);
    chk("select", 16'h0000, fb);
    chk("loop enable", 16'h0001, le);
    chk("gate", 16'h0000, oe);
    chk("update", 16'h0000, upd);
    chk("initial step", 16'h0101, ist);
    chk("mid step", 16'h0202, mq);
    chk("mid dwell", 16'h0000, mdw);
    chk("min dwell", 16'h0000, ndw);
    chk("div dwell", 16'h0000, vdw);
    chk("divider", 16'h0021, cdv);
    chk("offset target", 16'h0000, ot);
    wr(8'h39, 8'hFF);
    rd(8'h39, 8'h00);
    wr(8'h34, 8'hFF);
    wr(8'h35, 8'hA5);
    rd(8'h34, 8'h1F);
    chk("offset target", 13'h1FA5, ot);
    en = 0;
    wr(8'h35, 8'h00);
    en = 1;
    rd(8'h35, 8'hA5);
  endtask
  task automatic t_cfg;
    for (int i = 0; i < 8; i++) begin
      wr(8'h38, {i[2:0], 2'h0, i[1:0], 1'h1});
      chk("decimation", 8'h01 << i, dec);
      chk("select", i[1:0], fb);
      chk("loop enable", i[1:0] != 2'h3, le);
      rd(8'h38, {i[2:0], 2'h0, i[1:0], 1'h0});
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h3A, {4{i[1:0]}});
      wr(8'h36, {4{i[1:0]}});
      chk("dwell", {dwt[i], dwt[i]}, dw);
      chk("mid dwell", {sdt[i], sdt[i]}, mdw);
      chk("min dwell", {sdt[i], sdt[i]}, ndw);
      chk("div dwell", {dwt[i], dwt[i]}, vdw);
      rd(8'h36, {4{i[1:0]}});
    end
  endtask
  task automatic t_step;
    logic [7:0] q;
    for (int i = 0; i < 16; i++) begin
      q = i[1] ? 8'h00 : stt[i[3:2]] << !i[0];
      wr(8'h3B, {i[3:0], 2'h3, i[1:0]});
      wr(8'h37, {i[3:0], 2'h3, i[1:0]});
      chk("initial step", {2{stt[i[3:2]]}}, ist);
      chk("mid step", {q, q}, mq);
      chk("mid reserved", {2{i[1]}}, rsv);
      chk("divider", {cdt[i[1:0]], cdt[i[1:0]]}, cdv);
      rd(8'h3B, {i[3:0], 2'h0, i[1:0]});
      rd(8'h37, {i[3:0], 2'h0, i[1:0]});
    end
  endtask
  task automatic t_pins;
    wr(8'h38, 8'h10);
    pins(1, 0);
    chk("update unarmed", 0, upd);
    on = 1;
    pins(0, 0);
    on = 0;
    pins(1, 0);
    chk("update", 1, upd);
    chk("zero", 0, zer);
    pins(0, 0);
    pins(1, 0);
    chk("update spent", 0, upd);
    wr(8'h38, 8'h08);
    on = 1;
    pins(1, 0);
    chk("zero current", 1, zer);
    chk("no update", 0, upd);
    chk("gated off", 0, oe);
    pins(0, 1);
    chk("gated on", 1, oe);
    wr(8'h38, 8'h00);
    pins(0, 0);
    chk("ungated", 1, oe);
    on = 0;
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    t_regs();
    t_cfg();
    t_step();
    t_pins();
    complete_run();
  end
endmodule
`default_nettype wire
